// File: verilog/audio_route_mixer.sv
// Purpose: Routing, polarity, boost and level control of the digital audio paths
// Assumes: Sample strobes and register strobes synchronous to clk_sys
// Notes:   Two cycles mic to transmit slot, one cycle receive to playback
//
// Functional notes
// - Level controller start loads working gain from initial-gain field, default 0dB.
// - Initial-gain codes run -18dB to +36dB in 3dB steps; higher codes reserved.
// - Left transmit slot carries left mic on 0, right mic on 1.
// - Right transmit slot carries left mic on 0, right mic on 1; resets 1.
// - Left microphone channel is negated when its invert bit is set.
// - Right microphone channel is negated when its invert bit is set.
// - Data to the left playback converter is negated when bit 12 set.
// - Data to the right playback converter is negated when bit 11 set.
// - Left playback takes received left on 0, received right on 1.
// - Right playback takes received left on 0, received right on 1; resets 1.
// - Boost field scales received playback by 0, 6, 12 or 18 dB.
// - Both playback converters may take the same received channel for mono.
// - Level controller gains and compresses microphone samples before transmit.
//
// Implementation choice: strobed register access.

`timescale 1ns/100ps
`default_nettype none

module audio_route_mixer
  import audio_route_pkg::*;
#(
  parameter int W = 24
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [15:0]         reg_rdata,
  // Digital microphone samples
  input  wire logic signed [W-1:0] mic_left,
  input  wire logic signed [W-1:0] mic_right,
  input  wire logic                mic_valid,
  // Transmit slots of the audio interface
  output logic signed [W-1:0]      tx_left,
  output logic signed [W-1:0]      tx_right,
  output logic                     tx_valid,
  // Received interface samples (playback_serial_data channels)
  input  wire logic signed [W-1:0] rx_left,
  input  wire logic signed [W-1:0] rx_right,
  input  wire logic                rx_valid,
  // Playback converter feeds
  output logic signed [W-1:0]      play_left,
  output logic signed [W-1:0]      play_right,
  output logic                     play_valid
);

  // ****************************************************************
  // Local widths and helpers
  // ****************************************************************
  localparam int PW = W + 17;

  localparam logic signed [W-1:0] S_MAX = {1'b0, {(W-1){1'b1}}};
  localparam logic signed [W-1:0] S_MIN = {1'b1, {(W-1){1'b0}}};

  // Negate without wrap: the most negative code has no positive twin
  function automatic logic signed [W-1:0] sat_neg(input logic signed [W-1:0] x);
    if (x == S_MIN)
      sat_neg = S_MAX;
    else
      sat_neg = -x;
  endfunction : sat_neg

  // Clip a wide intermediate value to the sample range
  function automatic logic signed [W-1:0] sat_clip(input logic signed [PW-1:0] v);
    logic signed [PW-1:0] hi;
    logic signed [PW-1:0] lo;
    hi = PW'(S_MAX);
    lo = PW'(S_MIN);
    if (v > hi)
      sat_clip = S_MAX;
    else if (v < lo)
      sat_clip = S_MIN;
    else
      sat_clip = v[W-1:0];
  endfunction : sat_clip

  // True when a wide value lies outside the sample range
  function automatic logic is_clip(input logic signed [PW-1:0] v);
    is_clip = (v > PW'(S_MAX)) || (v < PW'(S_MIN));
  endfunction : is_clip

  // Linear gain in Q6.10 for each 3dB step from -18dB to +36dB
  function automatic logic [15:0] gain_coef(input logic [4:0] code);
    case (code)
      5'h00:   gain_coef = 16'h0081;
      5'h01:   gain_coef = 16'h00B6;
      5'h02:   gain_coef = 16'h0101;
      5'h03:   gain_coef = 16'h016B;
      5'h04:   gain_coef = 16'h0201;
      5'h05:   gain_coef = 16'h02D5;
      5'h06:   gain_coef = 16'h0400;
      5'h07:   gain_coef = 16'h05A6;
      5'h08:   gain_coef = 16'h07FB;
      5'h09:   gain_coef = 16'h0B46;
      5'h0A:   gain_coef = 16'h0FED;
      5'h0B:   gain_coef = 16'h167E;
      5'h0C:   gain_coef = 16'h1FC6;
      5'h0D:   gain_coef = 16'h2CE1;
      5'h0E:   gain_coef = 16'h3F65;
      5'h0F:   gain_coef = 16'h598C;
      5'h10:   gain_coef = 16'h7E7E;
      5'h11:   gain_coef = 16'hB2AC;
      5'h12:   gain_coef = 16'hFC62;
      default: gain_coef = COEF_UNITY;
    endcase
  endfunction : gain_coef

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [15:0] intf_route_q;
  logic [15:0] mic_ctrl_q;
  logic [15:0] level_ctrl_q;
  logic [15:0] reg_rdata_q;
  logic [15:0] rdata_d;

  wire sel_intf   = (reg_addr == ADDR_INTF_ROUTE);
  wire sel_mic    = (reg_addr == ADDR_MIC_CTRL);
  wire sel_level  = (reg_addr == ADDR_LEVEL_CTRL);
  wire sel_status = (reg_addr == ADDR_LEVEL_STATUS);

  // Writes keep only the implemented bits so reserved bits read zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      intf_route_q <= RST_INTF_ROUTE;
      mic_ctrl_q   <= RST_MIC_CTRL;
      level_ctrl_q <= RST_LEVEL_CTRL;
    end
    else if (reg_wr)
    begin
      if (sel_intf)
        intf_route_q <= reg_wdata & MASK_INTF_ROUTE;
      if (sel_mic)
        mic_ctrl_q <= reg_wdata & MASK_MIC_CTRL;
      if (sel_level)
        level_ctrl_q <= reg_wdata & MASK_LEVEL_CTRL;
    end
  end

  // Field decode
  wire       play_left_invert  = intf_route_q[POS_PLAY_L_INV];
  wire       play_right_invert = intf_route_q[POS_PLAY_R_INV];
  wire [1:0] play_boost        = intf_route_q[POS_BOOST_HI:POS_BOOST_LO];
  wire       tx_left_slot_source  = intf_route_q[POS_TX_L_SRC];
  wire       tx_right_slot_source = intf_route_q[POS_TX_R_SRC];
  wire       play_left_source  = intf_route_q[POS_PLAY_L_SRC];
  wire       play_right_source = intf_route_q[POS_PLAY_R_SRC];
  wire       mic_left_invert   = mic_ctrl_q[POS_MIC_L_INV];
  wire       mic_right_invert  = mic_ctrl_q[POS_MIC_R_INV];
  wire       level_ctrl_enable = level_ctrl_q[POS_LC_ENABLE];
  wire [4:0] level_ctrl_initial_gain = level_ctrl_q[POS_INIT_GAIN_HI:POS_INIT_GAIN_LO];

  // ****************************************************************
  // Microphone path, stage 1: polarity and slot routing
  // ****************************************************************
  logic signed [W-1:0] mic_s1_left_q;
  logic signed [W-1:0] mic_s1_right_q;
  logic                mic_s1_valid_q;

  wire signed [W-1:0] mic_l_pol = mic_left_invert ? sat_neg(mic_left) : mic_left;
  wire signed [W-1:0] mic_r_pol = mic_right_invert ? sat_neg(mic_right) : mic_right;
  wire signed [W-1:0] slot_l_d = tx_left_slot_source ? mic_r_pol : mic_l_pol;
  wire signed [W-1:0] slot_r_d = tx_right_slot_source ? mic_r_pol : mic_l_pol;

  // Samples outside a strobe are held so the gain stage sees stable data
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mic_s1_left_q  <= '0;
      mic_s1_right_q <= '0;
      mic_s1_valid_q <= 1'b0;
    end
    else
    begin
      mic_s1_valid_q <= mic_valid;
      if (mic_valid)
      begin
        mic_s1_left_q  <= slot_l_d;
        mic_s1_right_q <= slot_r_d;
      end
    end
  end

  // ****************************************************************
  // Level controller: working gain and compression
  // ****************************************************************
  lc_state_e lc_state_q;
  lc_state_e lc_state_d;
  logic [4:0] work_gain_q;
  logic [4:0] work_gain_d;

  // Reserved initial codes fall back to 0dB rather than an undefined gain
  // code range check
  wire       init_code_ok = (level_ctrl_initial_gain <= GAIN_CODE_MAX);
  wire [4:0] init_gain    = init_code_ok ? level_ctrl_initial_gain : GAIN_CODE_0DB;

  // Bypass at unity while the controller is idle
  // gain on mic path
  wire [15:0] lc_coef = (lc_state_q == LC_RUN) ? gain_coef(work_gain_q) : COEF_UNITY;

  wire signed [PW-1:0] prod_l = PW'(mic_s1_left_q  * $signed({1'b0, lc_coef}));
  wire signed [PW-1:0] prod_r = PW'(mic_s1_right_q * $signed({1'b0, lc_coef}));
  wire signed [PW-1:0] gain_l = prod_l >>> COEF_FRAC_BITS;
  wire signed [PW-1:0] gain_r = prod_r >>> COEF_FRAC_BITS;
  wire                 lc_clip = mic_s1_valid_q && (is_clip(gain_l) || is_clip(gain_r));

  // Clipping acts as a one-step attack; decay is not modelled
  always_comb
  begin
    lc_state_d  = lc_state_q;
    work_gain_d = work_gain_q;
    case (lc_state_q)
      LC_IDLE:
      begin
        if (level_ctrl_enable)
        begin
          lc_state_d  = LC_RUN;
          work_gain_d = init_gain;
        end
      end
      LC_RUN:
      begin
        if (!level_ctrl_enable)
          lc_state_d = LC_IDLE;
        else if (lc_clip && (work_gain_q != 5'h00))
          work_gain_d = work_gain_q - 5'h01;
      end
      default:
      begin
        lc_state_d  = LC_IDLE;
        work_gain_d = GAIN_CODE_0DB;
      end
    endcase
  end

  // Controller state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      lc_state_q  <= LC_IDLE;
      work_gain_q <= GAIN_CODE_0DB;
    end
    else
    begin
      lc_state_q  <= lc_state_d;
      work_gain_q <= work_gain_d;
    end
  end

  // ****************************************************************
  // Microphone path, stage 2: gained transmit slots
  // ****************************************************************
  logic signed [W-1:0] tx_left_q;
  logic signed [W-1:0] tx_right_q;
  logic                tx_valid_q;

  // Transmit slot registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_left_q  <= '0;
      tx_right_q <= '0;
      tx_valid_q <= 1'b0;
    end
    else
    begin
      tx_valid_q <= mic_s1_valid_q;
      if (mic_s1_valid_q)
      begin
        tx_left_q  <= sat_clip(gain_l);
        tx_right_q <= sat_clip(gain_r);
      end
    end
  end

  // ****************************************************************
  // Playback path: source, boost, polarity
  // ****************************************************************
  logic signed [W-1:0] play_left_q;
  logic signed [W-1:0] play_right_q;
  logic                play_valid_q;

  // Both selects may name one channel, which gives mono playback
  // left and right converter sources
  wire signed [W-1:0] src_l = play_left_source ? rx_right : rx_left;
  wire signed [W-1:0] src_r = play_right_source ? rx_right : rx_left;

  // Boost is a shift by whole 6dB steps; overshoot clips instead of wrapping
  // boost by shift
  wire signed [PW-1:0] boost_l = PW'(src_l) <<< play_boost;
  wire signed [PW-1:0] boost_r = PW'(src_r) <<< play_boost;
  wire signed [W-1:0]  clip_l  = sat_clip(boost_l);
  wire signed [W-1:0]  clip_r  = sat_clip(boost_r);

  wire signed [W-1:0] play_l_d = play_left_invert ? sat_neg(clip_l) : clip_l;
  wire signed [W-1:0] play_r_d = play_right_invert ? sat_neg(clip_r) : clip_r;

  // Playback converter feed registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      play_left_q  <= '0;
      play_right_q <= '0;
      play_valid_q <= 1'b0;
    end
    else
    begin
      play_valid_q <= rx_valid;
      if (rx_valid)
      begin
        play_left_q  <= play_l_d;
        play_right_q <= play_r_d;
      end
    end
  end

  // ****************************************************************
  // Register read-back
  // ****************************************************************
  // Unmapped addresses read zero
  assign rdata_d = sel_intf   ? intf_route_q :
                   sel_mic    ? mic_ctrl_q   :
                   sel_level  ? level_ctrl_q :
                   sel_status ? {11'h000, work_gain_q} : 16'h0000;

  // Read data stands for the one cycle after the strobe only
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata_q <= 16'h0000;
    else if (reg_rd)
      reg_rdata_q <= rdata_d;
    else
      reg_rdata_q <= 16'h0000;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata  = reg_rdata_q;
  assign tx_left    = tx_left_q;
  assign tx_right   = tx_right_q;
  assign tx_valid   = tx_valid_q;
  assign play_left  = play_left_q;
  assign play_right = play_right_q;
  assign play_valid = play_valid_q;

endmodule : audio_route_mixer

`default_nettype wire

// File: verilog/audio_route_pkg.sv
// Purpose: Shared constants for the digital audio routing and gain block
// Assumes: 16-bit control registers at their printed offsets
// Notes:   Field positions, reset values and gain codes live here only

package audio_route_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0]  ADDR_INTF_ROUTE   = 8'h18;
  localparam logic [7:0]  ADDR_MIC_CTRL     = 8'h26;
  localparam logic [7:0]  ADDR_LEVEL_CTRL   = 8'h28;
  localparam logic [7:0]  ADDR_LEVEL_STATUS = 8'h3F;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [15:0] RST_INTF_ROUTE    = 16'h0050;
  localparam logic [15:0] MASK_INTF_ROUTE   = 16'h1EF0;
  localparam logic [15:0] RST_MIC_CTRL      = 16'h0000;
  localparam logic [15:0] MASK_MIC_CTRL     = 16'h0003;
  localparam logic [15:0] RST_LEVEL_CTRL    = 16'h09AF;
  localparam logic [15:0] MASK_LEVEL_CTRL   = 16'h9FEF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int          POS_PLAY_L_INV    = 12;
  localparam int          POS_PLAY_R_INV    = 11;
  localparam int          POS_BOOST_HI      = 10;
  localparam int          POS_BOOST_LO      = 9;
  localparam int          POS_TX_L_SRC      = 7;
  localparam int          POS_TX_R_SRC      = 6;
  localparam int          POS_PLAY_L_SRC    = 5;
  localparam int          POS_PLAY_R_SRC    = 4;
  localparam int          POS_MIC_L_INV     = 1;
  localparam int          POS_MIC_R_INV     = 0;
  localparam int          POS_LC_ENABLE     = 15;
  localparam int          POS_INIT_GAIN_HI  = 10;
  localparam int          POS_INIT_GAIN_LO  = 6;

  // ****************************************************************
  // Gain codes and coefficient format
  // ****************************************************************
  localparam logic [4:0]  GAIN_CODE_0DB     = 5'h06;
  localparam logic [4:0]  GAIN_CODE_MAX     = 5'h12;
  localparam int          COEF_FRAC_BITS    = 10;
  localparam logic [15:0] COEF_UNITY        = 16'h0400;

  // Level controller states
  typedef enum logic [1:0] {
    LC_IDLE = 2'b00,
    LC_RUN  = 2'b01
  } lc_state_e;

endpackage : audio_route_pkg

// File: tb/audio_route_expect_pkg.sv
// Purpose: Expected sample values for the routing paths
// Assumes: 24-bit signed samples
// Notes:   Shared by the checker and the bench, never by the design

package audio_route_expect_pkg;

  localparam int SW = 24;
  typedef logic signed [SW-1:0] smp_t;
  localparam smp_t S_MAX = {1'b0, {(SW-1){1'b1}}};
  localparam smp_t S_MIN = {1'b1, {(SW-1){1'b0}}};

  // Negation; the most negative code saturates instead of wrapping
  function automatic smp_t neg(input smp_t x);
    return (x == S_MIN) ? S_MAX : -x;
  endfunction : neg

  // Transmit slot: pick a microphone, then its own inversion
  function automatic smp_t tx_exp(input logic sel, input logic [1:0] inv, input smp_t l, r);
    return sel ? (inv[0] ? neg(r) : r) : (inv[1] ? neg(l) : l);
  endfunction : tx_exp

  // Playback feed: pick a channel, boost with saturation, then invert
  function automatic smp_t play_exp(input logic sel, inv, input logic [1:0] b, input smp_t l, r);
    logic signed [SW+2:0] v;
    smp_t                 s;
    v = (sel ? r : l) <<< b;
    s = (v > S_MAX) ? S_MAX : ((v < S_MIN) ? S_MIN : v[SW-1:0]);
    return inv ? neg(s) : s;
  endfunction : play_exp

endpackage : audio_route_expect_pkg

// File: tb/audio_route_mixer_props.sv
// Purpose: Port-level checks of routing, polarity, boost and latency
// Assumes: Register mirror built from the write strobes seen at the ports
// Notes:   Microphone data is only judged while the level controller is idle
`timescale 1ns/100ps
`default_nettype none

module audio_route_mixer_props
  import audio_route_pkg::*;
  import audio_route_expect_pkg::*;
#(
  parameter int W = 24
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [15:0]         reg_rdata,
  input  wire logic signed [W-1:0] mic_left,
  input  wire logic signed [W-1:0] mic_right,
  input  wire logic                mic_valid,
  input  wire logic signed [W-1:0] tx_left,
  input  wire logic signed [W-1:0] tx_right,
  input  wire logic                tx_valid,
  input  wire logic signed [W-1:0] rx_left,
  input  wire logic signed [W-1:0] rx_right,
  input  wire logic                rx_valid,
  input  wire logic signed [W-1:0] play_left,
  input  wire logic signed [W-1:0] play_right,
  input  wire logic                play_valid
);
  logic [15:0] intf_q;
  logic [15:0] mic_q;
  logic [15:0] lvl_q;
  logic [15:0] rd_exp;
  logic [1:0]  quiet_q;

  // Register mirror; writes land at the strobe edge as in the block
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      intf_q <= 16'h0050;
      mic_q  <= 16'h0000;
      lvl_q  <= RST_LEVEL_CTRL;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_INTF_ROUTE) intf_q <= reg_wdata & MASK_INTF_ROUTE;
      if (reg_addr == ADDR_MIC_CTRL) mic_q <= reg_wdata & MASK_MIC_CTRL;
      if (reg_addr == ADDR_LEVEL_CTRL) lvl_q <= reg_wdata & MASK_LEVEL_CTRL;
    end
  end

  // Idle age of the controller; gain may linger a cycle after disable
  always_ff @(posedge clk_sys)
  begin
    if (rst || lvl_q[POS_LC_ENABLE])
      quiet_q <= 2'h0;
    else if (quiet_q != 2'h3)
      quiet_q <= quiet_q + 2'h1;
  end

  assign rd_exp = (reg_addr == ADDR_INTF_ROUTE) ? intf_q :
                  (reg_addr == ADDR_MIC_CTRL)   ? mic_q  :
                  (reg_addr == ADDR_LEVEL_CTRL) ? lvl_q  : 16'h0000;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_tx_lag:
    assert property (mic_valid |-> ##2 tx_valid) else $error("tx strobe late");
  a_tx_spurious:
    assert property (tx_valid |-> $past(mic_valid, 2)) else $error("tx strobe unasked");
  a_play_lag:
    assert property (play_valid == $past(rx_valid)) else $error("play strobe timing");
  a_tx_left_route:
    assert property (mic_valid && quiet_q == 2'h3 |-> ##2 tx_left == tx_exp(
      $past(intf_q[POS_TX_L_SRC], 2), $past(mic_q[1:0], 2), $past(mic_left, 2),
      $past(mic_right, 2))) else $error("left slot data wrong");
  a_tx_right_route:
    assert property (mic_valid && quiet_q == 2'h3 |-> ##2 tx_right == tx_exp(
      $past(intf_q[POS_TX_R_SRC], 2), $past(mic_q[1:0], 2), $past(mic_left, 2),
      $past(mic_right, 2))) else $error("right slot data wrong");
  a_play_left_path:
    assert property (rx_valid |=> play_left == play_exp($past(intf_q[POS_PLAY_L_SRC]),
      $past(intf_q[POS_PLAY_L_INV]), $past(intf_q[10:9]),
      $past(rx_left), $past(rx_right))) else $error("left playback data wrong");
  a_play_right_path:
    assert property (rx_valid |=> play_right == play_exp($past(intf_q[POS_PLAY_R_SRC]),
      $past(intf_q[POS_PLAY_R_INV]), $past(intf_q[10:9]),
      $past(rx_left), $past(rx_right))) else $error("right playback data wrong");
  a_mono_feed:
    assert property (rx_valid && intf_q[5] == intf_q[4] && intf_q[12] == intf_q[11]
      |=> play_left == play_right) else $error("mono feeds differ");
  a_read_back:
    assert property (reg_rd && reg_addr != ADDR_LEVEL_STATUS |=> reg_rdata == $past(rd_exp))
      else $error("read data wrong");

  c_mono: cover property (rx_valid && intf_q[5] == intf_q[4]);
  c_mic_inv: cover property (mic_valid && mic_q[1:0] == 2'h3);
  c_status: cover property (reg_rd && reg_addr == ADDR_LEVEL_STATUS);

endmodule : audio_route_mixer_props

bind audio_route_mixer audio_route_mixer_props #(.W(W)) i_audio_route_mixer_props (.clk_sys,
  .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mic_left, .mic_right, .mic_valid,
  .tx_left, .tx_right, .tx_valid, .rx_left, .rx_right, .rx_valid, .play_left, .play_right,
  .play_valid);

`default_nettype wire

// File: tb/audio_host_model.sv
// Purpose: Host on the serial audio side, sending received channel pairs
// Assumes: One request pulse per pair from the bench
// Notes:   Between pairs the data lines toggle so stale data cannot pass
`timescale 1ns/100ps
`default_nettype none

module audio_host_model
  import audio_route_pkg::*;
#(
  parameter int W = 24
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                req,
  input  wire logic [1:0]          boost,
  input  wire logic signed [W-1:0] req_left,
  input  wire logic signed [W-1:0] req_right,
  output logic signed [W-1:0]      rx_left,
  output logic signed [W-1:0]      rx_right,
  output logic                     rx_valid
);
  localparam logic signed [W-1:0] FULL = {1'b0, {(W-1){1'b1}}};

  function automatic logic signed [W-1:0] fit(input logic signed [W-1:0] x);
    logic signed [W-1:0] m;
    m = FULL >>> boost;
    return (x > m) ? m : ((x < -m) ? -m : x);
  endfunction : fit

  // One pair per request, registered like a real link
  always_ff @(posedge clk_sys)
  begin
    rx_valid <= req & ~rst;
    rx_left  <= rst ? '0 : (req ? fit(req_left) : ~rx_left);
    rx_right <= rst ? '0 : (req ? fit(req_right) : ~rx_right);
  end

endmodule : audio_host_model

`default_nettype wire

// File: tb/audio_route_mixer_tb_top.sv
// Purpose: Self-checking bench for routing, polarity, boost and level start
// Assumes: 10 MHz clock, synchronous active-high reset
// Notes:   Every routing and inversion code is set by loops
`timescale 1ns/100ps
`default_nettype none

module audio_route_mixer_tb_top;
  import audio_route_pkg::*;
  import audio_route_expect_pkg::*;

  localparam logic [4:0]  LC_CODE [5] = '{5'h00, 5'h06, 5'h08, 5'h12, 5'h13};
  localparam logic [15:0] LC_COEF [5] = '{16'h0081, 16'h0400, 16'h07FB, 16'hFC62, 16'h0400};
  localparam smp_t        S_L         = 24'sh123456;
  localparam smp_t        R_L         = 24'sh012345;
  localparam smp_t        R_R         = -24'sh0ABCDE;

  logic        clk_sys, rst, reg_wr, reg_rd, mic_valid, tx_valid, rx_valid, play_valid, req;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0]  hb;
  smp_t        mic_left, mic_right, tx_left, tx_right, rx_left, rx_right;
  smp_t        play_left, play_right, req_left, req_right;
  int          bad_count, compares;

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  audio_route_mixer #(.W(SW)) i_audio_route_mixer (.clk_sys, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .mic_left, .mic_right, .mic_valid, .tx_left, .tx_right,
    .tx_valid, .rx_left, .rx_right, .rx_valid, .play_left, .play_right, .play_valid);

  audio_host_model #(.W(SW)) i_audio_host_model (.clk_sys, .rst, .req, .boost(hb), .req_left,
    .req_right, .rx_left, .rx_right, .rx_valid);

  // ****************************************************************
  // Checks and bus tasks
  // ****************************************************************
  task automatic chk_reg(input logic [15:0] got, exp);
    chk_smp({8'h00, got}, {8'h00, exp});
  endtask : chk_reg

  task automatic chk_smp(input smp_t got, exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_smp

  task automatic summarize();
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk_reg(reg_rdata, exp);
  endtask : rd

  // Bounded wait for a one-cycle strobe; a hang ends the run
  task automatic wait_out(input logic play);
    int n = 0;
    #1;
    while ((play ? play_valid : tx_valid) !== 1'b1 && n < 5)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 5)
    begin
      bad_count++;
      summarize();
    end
  endtask : wait_out

  task automatic mic(input smp_t l, r, output smp_t tl, tr);
    @(posedge clk_sys);
    mic_valid <= 1'b1;
    mic_left  <= l;
    mic_right <= r;
    @(posedge clk_sys);
    mic_valid <= 1'b0;
    mic_left  <= ~l;
    mic_right <= ~r;
    wait_out(1'b0);
    tl = tx_left;
    tr = tx_right;
  endtask : mic

  task automatic rx(input smp_t l, r);
    @(posedge clk_sys);
    req       <= 1'b1;
    req_left  <= l;
    req_right <= r;
    @(posedge clk_sys);
    req <= 1'b0;
    wait_out(1'b1);
  endtask : rx

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rd(ADDR_INTF_ROUTE, 16'h0050);
    rd(ADDR_MIC_CTRL, 16'h0000);
    rd(ADDR_LEVEL_CTRL, RST_LEVEL_CTRL);
    wr(ADDR_LEVEL_STATUS, 16'h001F);
    rd(ADDR_LEVEL_STATUS, 16'h0006);
    wr(8'h20, 16'hFFFF);
    rd(8'h20, 16'h0000);
    wr(ADDR_INTF_ROUTE, 16'hFFFF);
    rd(ADDR_INTF_ROUTE, MASK_INTF_ROUTE);
    $display("Test registers done");
  endtask : t_regs

  // Every slot source and invert pair, with the most negative right sample
  task automatic t_tx();
    smp_t tl, tr;
    for (int s = 0; s < 4; s++)
      for (int v = 0; v < 4; v++)
      begin
        wr(ADDR_INTF_ROUTE, 16'(s << 6));
        wr(ADDR_MIC_CTRL, 16'(v));
        mic(S_L, S_MIN, tl, tr);
        chk_smp(tl, tx_exp(s[1], 2'(v), S_L, S_MIN));
        chk_smp(tr, tx_exp(s[0], 2'(v), S_L, S_MIN));
      end
    $display("Test transmit routing done");
  endtask : t_tx

  // Sources, inversions and boosts; equal sources give mono
  task automatic t_play();
    for (int s = 0; s < 4; s++)
      for (int v = 0; v < 4; v++)
        for (int b = 0; b < 4; b++)
        begin
          wr(ADDR_INTF_ROUTE, 16'((v << 11) | (b << 9) | (s << 4)));
          hb <= 2'(b);
          rx(R_L, R_R);
          chk_smp(play_left, play_exp(s[1], v[1], 2'(b), R_L, R_R));
          chk_smp(play_right, play_exp(s[0], v[0], 2'(b), R_L, R_R));
        end
    $display("Test playback routing done");
  endtask : t_play

  // Start gains incl. a reserved one, and a clipping sample
  task automatic t_level();
    smp_t tl, tr;
    wr(ADDR_INTF_ROUTE, 16'h0050);
    wr(ADDR_MIC_CTRL, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_LEVEL_CTRL, (RST_LEVEL_CTRL & 16'hF83F) | 16'h8000 | (16'(LC_CODE[i]) << 6));
      repeat (2) @(posedge clk_sys);
      rd(ADDR_LEVEL_STATUS, (i == 4) ? 16'h0006 : 16'(LC_CODE[i]));
      mic(24'sh001000, 24'sh001000, tl, tr);
      chk_smp(tl, {6'h00, LC_COEF[i], 2'b00});
      chk_smp(tr, {6'h00, LC_COEF[i], 2'b00});
      if (i == 3)
      begin
        mic(S_L, S_L, tl, tr);
        chk_smp(tl, S_MAX);
        rd(ADDR_LEVEL_STATUS, 16'h0011);
      end
      wr(ADDR_LEVEL_CTRL, RST_LEVEL_CTRL);
    end
    $display("Test level start done");
  endtask : t_level

  initial
  begin
    bad_count = 0;
    compares  = 0;
    rst       = 1'b1;
    {reg_wr, reg_rd, mic_valid, req} = 4'h0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    hb        = 2'h0;
    {mic_left, mic_right, req_left, req_right} = '0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_tx();
    t_play();
    t_level();
    summarize();
  end

endmodule : audio_route_mixer_tb_top

`default_nettype wire
